/* pio_pkg.sv */
// shared constants, types and helpers for the parallel port block
`default_nettype none
package pio_pkg;
    // register addresses
    localparam logic [7:0] ADDR_PORT0   = 8'h00;
    localparam logic [7:0] ADDR_PORT1   = 8'h01;
    localparam logic [7:0] ADDR_PORT2   = 8'h02;
    localparam logic [7:0] ADDR_P2DIR   = 8'hf6;
    localparam logic [7:0] ADDR_P3MODE  = 8'hf7;
    localparam logic [7:0] ADDR_P01DIR  = 8'hf8;
    // reset values: every port comes up as input, no handshake
    localparam logic [7:0] RST_P01DIR   = 8'h49;
    localparam logic [7:0] RST_P2DIR    = 8'hff;
    localparam logic [7:0] RST_P3MODE   = 8'h00;
    localparam logic [7:0] RST_DATA     = 8'h00;
    // field positions
    localparam int P01_LO_LSB  = 0;
    localparam int P01_PB_LSB  = 3;
    localparam int P01_HI_LSB  = 6;
    localparam int MOD_P0_HS   = 2;
    localparam int MOD_PB_LSB  = 3;
    localparam int MOD_PC_HS   = 6;
    localparam int PC_SER_IN   = 0;
    localparam int PC_MASTER   = 7;
    // two-bit direction codes and the port one handshake mode code
    localparam logic [1:0] DIR_OUT = 2'h0;
    localparam logic [1:0] DIR_IN  = 2'h1;
    localparam logic [1:0] HS_BOTH = 2'h3;
    // handshake states, gray along idle -> held -> release
    typedef enum logic [1:0] {
        HS_IDLE    = 2'h0,
        HS_HELD    = 2'h1,
        HS_RELEASE = 2'h3
    } hs_state_t;

    function automatic logic dir_is_out(input logic [1:0] code);
        return code == DIR_OUT;
    endfunction : dir_is_out

    function automatic logic dir_is_in(input logic [1:0] code);
        return code == DIR_IN;
    endfunction : dir_is_in
endpackage : pio_pkg
`default_nettype wire

/* port_handshake.sv */
// two-flop level synchroniser and the interlocked handshake engine
`default_nettype none
module level_sync2 (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    // first flop feeds the second only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            dout   <= 1'b1;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : level_sync2

module port_handshake
    import pio_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              enable,
    input  wire logic              dir_in,
    input  wire logic              line_in,
    input  wire logic              rd_pulse,
    input  wire logic              wr_pulse,
    input  wire logic [DATA_W-1:0] pin_data,
    output logic                   line_out,
    output logic      [DATA_W-1:0] latch_q
);
    if (DATA_W < 1) begin : g_chk
        $error("port_handshake: DATA_W must be at least 1");
    end

    logic      line_s;
    logic      line_d;
    logic      cap;
    hs_state_t state_q;
    hs_state_t state_d;

    level_sync2 u_sync (
        .mclk (mclk),
        .rst_n(rst_n),
        .din  (line_in),
        .dout (line_s)
    );

    always_comb begin
        state_d = state_q;
        line_d  = line_out;
        cap     = 1'b0;
        if (!enable) begin
            state_d = HS_IDLE;
            line_d  = 1'b1;
        end else if (dir_in) begin
            case (state_q)
                HS_IDLE: begin
                    line_d = 1'b1;
                    if (!line_s) begin
                        cap     = 1'b1;
                        line_d  = 1'b0;
                        state_d = HS_HELD;
                    end
                end
                HS_HELD: begin
                    if (rd_pulse) begin
                        state_d = HS_RELEASE;
                    end
                end
                HS_RELEASE: begin
                    if (line_s) begin
                        line_d  = 1'b1;
                        state_d = HS_IDLE;
                    end
                end
                default: begin
                    state_d = HS_IDLE;
                end
            endcase
        end else begin
            case (state_q)
                HS_IDLE: begin
                    line_d = 1'b1;
                    if (wr_pulse && line_s) begin
                        line_d  = 1'b0;
                        state_d = HS_HELD;
                    end
                end
                HS_HELD: begin
                    if (!line_s) begin
                        line_d  = 1'b1;
                        state_d = HS_IDLE;
                    end
                end
                default: begin
                    state_d = HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= HS_IDLE;
            line_out <= 1'b1;
            latch_q  <= '0;
        end else begin
            state_q  <= state_d;
            line_out <= line_d;
            if (cap) begin
                latch_q <= pin_data;
            end
        end
    end

    a_out_strobe_low : assert property (@(posedge mclk) disable iff (!rst_n)
        enable && !dir_in && state_q == HS_IDLE && wr_pulse && line_s
        |=> !line_out [*1] ##0 state_q == HS_HELD)
        else $error("output strobe not asserted on write");
    a_latch_hold : assert property (@(posedge mclk) disable iff (!rst_n)
        enable && dir_in && state_q != HS_IDLE && $stable(enable)
        |=> $stable(latch_q))
        else $error("held input data overwritten");
    a_ready_return : assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(line_out) && enable && $past(enable) && dir_in
        |-> $past(state_q) == HS_RELEASE && $past(line_s))
        else $error("ready raised before read and strobe high");
endmodule : port_handshake
`default_nettype wire

/* parallel_ports_handshake_select.sv */
// three parallel ports with direction control and interlocked handshake
// Functional notes
// - mode bit D2 puts port zero under handshake
// - port zero uses lines two and five
// - port zero handshake follows upper nibble direction
// - port one byte out 00, in 01
// - port one data at 01h, read returns data
// - output bits read back the pin level
// - handshake inputs read the strobed latch
// - mode bits D4:D3 both set: port one handshake
// - port one uses lines three and four
// - port one handshake follows byte direction
// - port two per-bit direction, 1 is input
// - serial enable takes bit 0 and 7
// - port two write drives outputs at once
// - mode bit 6 puts port two under handshake
// - port two uses lines one and six
// - port two handshake follows bit 7 direction
// - port zero nibbles coded 00 out, 01 in
// - first strobe latches, held until port read
// - ready low after latch, high after read
// - write strobes only while ready is high
`default_nettype none
module parallel_ports_handshake_select
    import pio_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] port_zero_in,
    output logic      [7:0] port_zero_out,
    output logic      [7:0] port_zero_oe_n,
    input  wire logic [7:0] port_one_in,
    output logic      [7:0] port_one_out,
    output logic      [7:0] port_one_oe_n,
    input  wire logic [7:0] port_two_in,
    output logic      [7:0] port_two_out,
    output logic      [7:0] port_two_oe_n,
    input  wire logic       hs_line_one,
    input  wire logic       hs_line_two,
    input  wire logic       hs_line_three,
    output logic            hs_line_four,
    output logic            hs_line_five,
    output logic            hs_line_six,
    input  wire logic       spi_enable,
    input  wire logic       spi_data_out,
    output logic            serial_data_in
);
    // configuration registers
    logic [7:0] p01_dir_q;
    logic [7:0] pc_dir_q;
    logic [7:0] p3_mode_q;
    logic [7:0] pc_data_q;

    // address decode
    wire hit_p0  = reg_addr == ADDR_PORT0;
    wire hit_pb  = reg_addr == ADDR_PORT1;
    wire hit_pc  = reg_addr == ADDR_PORT2;
    wire hit_pcm = reg_addr == ADDR_P2DIR;
    wire hit_p3m = reg_addr == ADDR_P3MODE;
    wire hit_p01 = reg_addr == ADDR_P01DIR;

    wire wr_p0  = reg_wr && hit_p0;
    wire wr_pb  = reg_wr && hit_pb;
    wire wr_pc  = reg_wr && hit_pc;
    wire wr_pcm = reg_wr && hit_pcm;
    wire wr_p3m = reg_wr && hit_p3m;
    wire wr_p01 = reg_wr && hit_p01;
    wire rd_p0  = reg_rd && hit_p0;
    wire rd_pb  = reg_rd && hit_pb;
    wire rd_pc  = reg_rd && hit_pc;

    // direction fields
    wire [1:0] p0_lo_code = p01_dir_q[P01_LO_LSB +: 2];
    wire [1:0] p0_hi_code = p01_dir_q[P01_HI_LSB +: 2];
    wire [1:0] pb_code    = p01_dir_q[P01_PB_LSB +: 2];

    // codes other than 00 and 01 leave the pins undriven
    wire p0_lo_out = dir_is_out(p0_lo_code);
    wire p0_hi_out = dir_is_out(p0_hi_code);
    wire p0_hi_in  = dir_is_in(p0_hi_code);
    wire pb_out    = dir_is_out(pb_code);
    wire pb_in     = dir_is_in(pb_code);

    // handshake enables
    wire hs0_en = p3_mode_q[MOD_P0_HS];
    wire hs1_en = p3_mode_q[MOD_PB_LSB +: 2] == HS_BOTH;
    wire hs2_en = p3_mode_q[MOD_PC_HS];

    // handshake directions
    wire hs0_dir_in = p0_hi_in;
    wire hs1_dir_in = pb_in;
    wire hs2_dir_in = pc_dir_q[PC_MASTER];

    // lower nibble joins only when coded like the upper one
    wire       p0_lo_same = p0_lo_code == p0_hi_code;
    wire [7:0] hs0_mask   = {4'hf, {4{p0_lo_same}}};
    wire [7:0] hs2_mask   = ~(pc_dir_q ^ {8{hs2_dir_in}});

    // handshake engine outputs
    wire       hs0_line;
    wire       hs1_line;
    wire       hs2_line;
    wire [7:0] hs0_latch;
    wire [7:0] hs1_latch;
    wire [7:0] hs2_latch;

    // read select: masked input bits under handshake show the latch
    function automatic logic [7:0] port_read(
        input logic       en,
        input logic       dir_in,
        input logic [7:0] mask,
        input logic [7:0] latch,
        input logic [7:0] pins
    );
        logic [7:0] sel;
        sel = (en && dir_in) ? mask : 8'h00;
        return (latch & sel) | (pins & ~sel);
    endfunction : port_read

    wire [7:0] rd_data_p0 =
        port_read(hs0_en, hs0_dir_in, hs0_mask, hs0_latch,
                  port_zero_in);
    wire [7:0] rd_data_pb =
        port_read(hs1_en, hs1_dir_in, 8'hff, hs1_latch,
                  port_one_in);
    wire [7:0] rd_data_pc =
        port_read(hs2_en, hs2_dir_in, hs2_mask, hs2_latch,
                  port_two_in);

    // mode register reads as zero since it is write-only
    wire [7:0] rdata_d =
        hit_p0  ? rd_data_p0 :
        hit_pb  ? rd_data_pb :
        hit_pc  ? rd_data_pc :
        hit_pcm ? pc_dir_q   :
        hit_p01 ? p01_dir_q  : 8'h00;

    // next pin drive
    wire [7:0] p0_oe_n_d = ~{{4{p0_hi_out}}, {4{p0_lo_out}}};
    wire [7:0] pb_oe_n_d = {8{~pb_out}};
    wire [7:0] pc_oe_n_spi =
        {1'b0, pc_dir_q[6:1], 1'b1};
    wire [7:0] pc_oe_n_d = spi_enable ? pc_oe_n_spi
                                      : pc_dir_q;
    // write data reaches the pins on the same edge it is stored
    wire [7:0] pc_data_d = wr_pc ? reg_wdata : pc_data_q;
    wire [7:0] pc_out_d  = spi_enable
                         ? {spi_data_out, pc_data_d[6:0]}
                         : pc_data_d;

    // handshake engines; line pairs are fixed per port
    port_handshake #(.DATA_W(8)) u_hs0 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .enable  (hs0_en),
        .dir_in  (hs0_dir_in),
        .line_in (hs_line_two),
        .rd_pulse(rd_p0),
        .wr_pulse(wr_p0),
        .pin_data(port_zero_in),
        .line_out(hs0_line),
        .latch_q (hs0_latch)
    );

    port_handshake #(.DATA_W(8)) u_hs1 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .enable  (hs1_en),
        .dir_in  (hs1_dir_in),
        .line_in (hs_line_three),
        .rd_pulse(rd_pb),
        .wr_pulse(wr_pb),
        .pin_data(port_one_in),
        .line_out(hs1_line),
        .latch_q (hs1_latch)
    );

    port_handshake #(.DATA_W(8)) u_hs2 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .enable  (hs2_en),
        .dir_in  (hs2_dir_in),
        .line_in (hs_line_one),
        .rd_pulse(rd_pc),
        .wr_pulse(wr_pc),
        .pin_data(port_two_in),
        .line_out(hs2_line),
        .latch_q (hs2_latch)
    );

    // engine outputs are flops; retimed once more to keep pins registered
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hs_line_four <= 1'b1;
            hs_line_five <= 1'b1;
            hs_line_six  <= 1'b1;
        end else begin
            hs_line_four <= hs1_line;
            hs_line_five <= hs0_line;
            hs_line_six  <= hs2_line;
        end
    end

    // configuration registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p01_dir_q <= RST_P01DIR;
            pc_dir_q  <= RST_P2DIR;
            p3_mode_q <= RST_P3MODE;
        end else begin
            if (wr_p01) begin
                p01_dir_q <= reg_wdata;
            end
            if (wr_pcm) begin
                pc_dir_q <= reg_wdata;
            end
            if (wr_p3m) begin
                p3_mode_q <= reg_wdata;
            end
        end
    end

    // output registers; input ports still store writes for later use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_zero_out <= RST_DATA;
            port_one_out  <= RST_DATA;
            pc_data_q     <= RST_DATA;
            port_two_out  <= RST_DATA;
        end else begin
            if (wr_p0) begin
                port_zero_out <= reg_wdata;
            end
            if (wr_pb) begin
                port_one_out <= reg_wdata;
            end
            pc_data_q    <= pc_data_d;
            port_two_out <= pc_out_d;
        end
    end

    // pin enables and serial input tap
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_zero_oe_n <= 8'hff;
            port_one_oe_n  <= 8'hff;
            port_two_oe_n  <= 8'hff;
            serial_data_in <= 1'b1;
        end else begin
            port_zero_oe_n <= p0_oe_n_d;
            port_one_oe_n  <= pb_oe_n_d;
            port_two_oe_n  <= pc_oe_n_d;
            serial_data_in <= port_two_in[PC_SER_IN];
        end
    end

    // read data answers one cycle after the read and then holds
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    a_p0_hs_idle : assert property (@(posedge mclk) disable iff (!rst_n)
        !hs0_en ##1 !hs0_en |=> hs_line_five)
        else $error("port zero line five moved without handshake");
    a_pb_dir_out : assert property (@(posedge mclk) disable iff (!rst_n)
        pb_code == DIR_OUT |=> port_one_oe_n == 8'h00)
        else $error("port one not driven as output");
    a_pb_dir_in : assert property (@(posedge mclk) disable iff (!rst_n)
        pb_code == DIR_IN |=> port_one_oe_n == 8'hff)
        else $error("port one driven while input");
    a_pb_write : assert property (@(posedge mclk) disable iff (!rst_n)
        wr_pb |=> port_one_out == $past(reg_wdata))
        else $error("port one write not stored");
    a_pb_read_pin : assert property (@(posedge mclk) disable iff (!rst_n)
        rd_pb && pb_out |=> reg_rdata == $past(port_one_in))
        else $error("port one output read not pin level");
    a_pc_dir_bits : assert property (@(posedge mclk) disable iff (!rst_n)
        !spi_enable |=> port_two_oe_n == $past(pc_dir_q))
        else $error("port two drive does not follow direction");
    a_pc_write_out : assert property (@(posedge mclk) disable iff (!rst_n)
        wr_pc |=> port_two_out[6:0] == $past(reg_wdata[6:0]))
        else $error("port two write not driven at once");
    a_spi_override : assert property (@(posedge mclk) disable iff (!rst_n)
        spi_enable |=> port_two_out[PC_MASTER] == $past(spi_data_out)
            && port_two_oe_n[PC_SER_IN])
        else $error("serial override not applied");
    a_pc_hs_read : assert property (@(posedge mclk) disable iff (!rst_n)
        rd_pc && hs2_en && hs2_dir_in && hs2_mask[PC_MASTER]
        |=> reg_rdata[PC_MASTER] == $past(hs2_latch[PC_MASTER]))
        else $error("handshake input read not from latch");
endmodule : parallel_ports_handshake_select
`default_nettype wire

/* pio_peripheral.sv */
// far-side peripheral: pin levels and the interlocked handshake partner
`default_nettype none
module pio_peripheral (
    input  wire logic       mclk,
    input  wire logic [7:0] port_zero_out,
    input  wire logic [7:0] port_zero_oe_n,
    input  wire logic [7:0] port_one_out,
    input  wire logic [7:0] port_one_oe_n,
    input  wire logic [7:0] port_two_out,
    input  wire logic [7:0] port_two_oe_n,
    input  wire logic       hs_line_four,
    input  wire logic       hs_line_five,
    input  wire logic       hs_line_six,
    output logic      [7:0] port_zero_in,
    output logic      [7:0] port_one_in,
    output logic      [7:0] port_two_in,
    output logic            hs_line_one,
    output logic            hs_line_two,
    output logic            hs_line_three
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       [7:0] ext  [3] = '{8'h00, 8'h00, 8'h00};
    logic       [7:0] pull [3] = '{8'hff, 8'hff, 8'hff};
    logic       [2:0] hs_q     = 3'h7;
    wire  logic [2:0] from_dut = {hs_line_six, hs_line_four, hs_line_five};
    // a driven bit reads back through any external pull-down
    assign port_zero_in  = (port_zero_out & pull[0] & ~port_zero_oe_n)
                         | (ext[0] & port_zero_oe_n);
    assign port_one_in   = (port_one_out & pull[1] & ~port_one_oe_n)
                         | (ext[1] & port_one_oe_n);
    assign port_two_in   = (port_two_out & pull[2] & ~port_two_oe_n)
                         | (ext[2] & port_two_oe_n);
    assign hs_line_one   = hs_q[2];
    assign hs_line_two   = hs_q[0];
    assign hs_line_three = hs_q[1];

    task automatic wait_line(input int ch, input logic lvl, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge mclk);
            #2;
            ok = (from_dut[ch] === lvl);
        end
    endtask : wait_line

    task automatic send(input int ch, input logic [7:0] d, output bit ok);
        ext[ch] = d;
        @(posedge mclk);
        #2;
        hs_q[ch] = 1'b0;
        wait_line(ch, 1'b0, ok);
        hs_q[ch] = 1'b1;
    endtask : send

    // extra strobe while the latch is still full
    task automatic pulse(input int ch, input logic [7:0] d);
        ext[ch] = d;
        hs_q[ch] = 1'b0;
        repeat (3) @(posedge mclk);
        #2;
        hs_q[ch] = 1'b1;
    endtask : pulse

    task automatic recv(input int ch, output logic [7:0] d, output bit ok);
        bit ok2;
        wait_line(ch, 1'b0, ok);
        d = (ch == 0) ? port_zero_in : (ch == 1) ? port_one_in : port_two_in;
        hs_q[ch] = 1'b0;
        wait_line(ch, 1'b1, ok2);
        hs_q[ch] = 1'b1;
        ok = ok & ok2;
    endtask : recv
endmodule : pio_peripheral
`default_nettype wire

/* parallel_ports_handshake_select_tb.sv */
// register-level testbench of the three parallel ports
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module parallel_ports_handshake_select_tb
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk, rst_n, reg_wr, reg_rd, spi_enable, spi_data_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
    logic [7:0] port_zero_in, port_zero_out, port_zero_oe_n;
    logic [7:0] port_one_in, port_one_out, port_one_oe_n;
    logic [7:0] port_two_in, port_two_out, port_two_oe_n;
    logic       hs_line_one, hs_line_two, hs_line_three;
    logic       hs_line_four, hs_line_five, hs_line_six, serial_data_in;
    bit         ok;
    int         failures = 0;
    int         n_checks = 0;
    logic [7:0] hs_mode [3] = '{8'h04, 8'h18, 8'h40};
    logic [7:0] hs_addr [3] = '{ADDR_PORT0, ADDR_PORT1, ADDR_PORT2};
    logic [7:0] hs_data [3] = '{8'h3c, 8'ha5, 8'h96};

    parallel_ports_handshake_select dut (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .port_zero_in(port_zero_in), .port_zero_out(port_zero_out),
        .port_zero_oe_n(port_zero_oe_n), .port_one_in(port_one_in),
        .port_one_out(port_one_out), .port_one_oe_n(port_one_oe_n),
        .port_two_in(port_two_in), .port_two_out(port_two_out),
        .port_two_oe_n(port_two_oe_n), .hs_line_one(hs_line_one),
        .hs_line_two(hs_line_two), .hs_line_three(hs_line_three),
        .hs_line_four(hs_line_four), .hs_line_five(hs_line_five),
        .hs_line_six(hs_line_six), .spi_enable(spi_enable),
        .spi_data_out(spi_data_out), .serial_data_in(serial_data_in));

    pio_peripheral p (
        .mclk(mclk), .port_zero_out(port_zero_out),
        .port_zero_oe_n(port_zero_oe_n), .port_one_out(port_one_out),
        .port_one_oe_n(port_one_oe_n), .port_two_out(port_two_out),
        .port_two_oe_n(port_two_oe_n), .hs_line_four(hs_line_four),
        .hs_line_five(hs_line_five), .hs_line_six(hs_line_six),
        .port_zero_in(port_zero_in), .port_one_in(port_one_in),
        .port_two_in(port_two_in), .hs_line_one(hs_line_one),
        .hs_line_two(hs_line_two), .hs_line_three(hs_line_three));

    task automatic tick();
        @(posedge mclk);
        #2;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                          input string nm);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        `CHK(nm, e, reg_rdata)
    endtask : rd_chk

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        spi_enable = 1'b0;
        spi_data_out = 1'b0;
        repeat (8) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        tick();
        `CHK("oe rst", 24'hffffff, {port_zero_oe_n, port_one_oe_n, port_two_oe_n})
        `CHK("hs rst", 3'h7, {hs_line_four, hs_line_five, hs_line_six})
        rd_chk(ADDR_P01DIR, RST_P01DIR, "f8 rst");
        rd_chk(ADDR_P2DIR, RST_P2DIR, "f6 rst");
        wr(ADDR_P3MODE, 8'h18);
        rd_chk(ADDR_P3MODE, 8'h00, "f7 wo");
        wr(ADDR_P3MODE, 8'h00);
        wr(8'h55, 8'hff);
        rd_chk(8'h55, 8'h00, "unmapped");
        // general i/o: port one bits 3:0 pulled low outside
        p.pull[1] = 8'hf0;
        p.ext[0] = 8'h96;
        p.ext[1] = 8'h81;
        p.ext[2] = 8'h5a;
        wr(ADDR_P01DIR, 8'h00);
        wr(ADDR_P2DIR, 8'h0f);
        wr(ADDR_PORT0, 8'hc3);
        wr(ADDR_PORT1, 8'hff);
        wr(ADDR_PORT2, 8'h3c);
        `CHK("p2 out", 8'h3c, port_two_out)
        tick();
        tick();
        `CHK("p0 oe", 8'h00, port_zero_oe_n)
        `CHK("p1 oe", 8'h00, port_one_oe_n)
        `CHK("p2 oe", 8'h0f, port_two_oe_n)
        rd_chk(ADDR_PORT1, 8'hf0, "p1 pins");
        rd_chk(ADDR_PORT2, 8'h3a, "p2 pins");
        rd_chk(ADDR_PORT0, 8'hc3, "p0 pins");
        rd_chk(ADDR_P2DIR, 8'h0f, "f6 rw");
        wr(ADDR_P01DIR, 8'h09);
        tick();
        tick();
        `CHK("p0 oe nib", 8'h0f, port_zero_oe_n)
        `CHK("p1 oe in", 8'hff, port_one_oe_n)
        rd_chk(ADDR_PORT0, 8'hc6, "p0 mix");
        rd_chk(ADDR_PORT1, 8'h81, "p1 in");
        // serial mode overrides the direction register on bits 0 and 7
        spi_enable = 1'b1;
        spi_data_out = 1'b1;
        wr(ADDR_P2DIR, 8'h00);
        p.ext[2] = 8'h01;
        repeat (3) tick();
        `CHK("spi out", 2'h2, {port_two_out[7], port_two_oe_n[7]})
        `CHK("spi in oe", 1'b1, port_two_oe_n[0])
        `CHK("spi din", 1'b1, serial_data_in)
        p.ext[2] = 8'h00;
        tick();
        tick();
        `CHK("spi din lo", 1'b0, serial_data_in)
        spi_enable = 1'b0;
        // input handshake on each port in turn
        wr(ADDR_P01DIR, RST_P01DIR);
        wr(ADDR_P2DIR, RST_P2DIR);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_P3MODE, hs_mode[i]);
            p.send(i, hs_data[i], ok);
            `CHK("in rdy low", 1'b1, ok)
            p.pulse(i, 8'h00);
            repeat (6) tick();
            `CHK("rdy held", 1'b0, p.from_dut[i])
            rd_chk(hs_addr[i], hs_data[i], "in latch");
            p.wait_line(i, 1'b1, ok);
            `CHK("rdy back", 1'b1, ok)
        end
        // output handshake on each port in turn
        wr(ADDR_P3MODE, 8'h00);
        wr(ADDR_P01DIR, 8'h00);
        wr(ADDR_P2DIR, 8'h00);
        p.pull[1] = 8'hff;
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_P3MODE, hs_mode[i]);
            fork
                p.recv(i, got, ok);
                wr(hs_addr[i], ~hs_data[i]);
            join
            `CHK("out hs", 1'b1, ok)
            `CHK("out data", ~hs_data[i], got)
        end
        // a write while ready is low stores data but raises no strobe
        wr(ADDR_P3MODE, 8'h18);
        p.hs_q[1] = 1'b0;
        repeat (4) tick();
        wr(ADDR_PORT1, 8'h77);
        repeat (8) tick();
        `CHK("no strobe", 1'b1, hs_line_four)
        `CHK("data kept", 8'h77, port_one_out)
        p.hs_q[1] = 1'b1;
        finish_test();
    end
endmodule : parallel_ports_handshake_select_tb
`default_nettype wire
